// ---- pin_function_pullup_control.sv ----
// Top of the shared-pin function select and pull-up control block
`timescale 1ns/1ps
`default_nettype none
module pin_function_pullup_control
  import pin_mux_pkg::*;
#(
  // 1 for full-featured variant, 0 for reduced variant
  parameter bit FULL_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Function configuration, one select per pin
  input wire logic cfg_write_i,
  input wire logic [1:0] cfg_func_rx_i,
  input wire logic [1:0] cfg_func_tx_i,
  input wire logic [1:0] cfg_func_t0_i,
  input wire logic [1:0] cfg_func_t1_i,
  // Port settings for this group
  input wire logic [3:0] pullup_enable_reg_i,
  input wire logic [3:0] port_dir_i,
  input wire logic [3:0] port_open_drain_i,
  input wire logic [3:0] port_data_i,
  // Controller-network transmit data
  input wire logic net_tx_i,
  // Timer channel outputs
  input wire logic [1:0] tmr_out_i,
  input wire logic [1:0] tmr_oe_i,
  // Serial port transmit data
  input wire logic serial_tx_alt_i,
  // Pad input levels
  input wire logic [3:0] pad_in_i,
  // Pad controls
  output logic [3:0] pad_out_o,
  output logic [3:0] pad_oe_o,
  output logic [3:0] pad_pullup_o,
  // Received data to peripherals
  output logic net_rx_o,
  output logic [1:0] tmr_in_o,
  output logic serial_rx_alt_o,
  output logic [3:0] port_in_o,
  // Current function of each pin, two bits per pin
  output logic [7:0] func_sel_o
);

  // Function select registers
  pin_func_t func_q [NUM_PINS];
  pin_func_t func_d [NUM_PINS];
  // Default for network pins depends on variant
  localparam pin_func_t NET_DEFAULT = FULL_VARIANT ? FUNC_PERIPH : FUNC_NONE;

  // Per-pin drive request
  wire logic [3:0] drv_en;
  wire logic [3:0] drv_val;
  wire logic [3:0] drv_od;
  wire logic [3:0] pu_bit;

  // Next function selects
  assign func_d[PIN_NET_RX] = cfg_write_i ? pin_func_t'(cfg_func_rx_i) : func_q[PIN_NET_RX];
  assign func_d[PIN_NET_TX] = cfg_write_i ? pin_func_t'(cfg_func_tx_i) : func_q[PIN_NET_TX];
  assign func_d[PIN_TMR0] = cfg_write_i ? pin_func_t'(cfg_func_t0_i) : func_q[PIN_TMR0];
  assign func_d[PIN_TMR1] = cfg_write_i ? pin_func_t'(cfg_func_t1_i) : func_q[PIN_TMR1];

  // Function registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      func_q[PIN_NET_RX] <= NET_DEFAULT;
      func_q[PIN_NET_TX] <= NET_DEFAULT;
      func_q[PIN_TMR0] <= FUNC_PERIPH;
      func_q[PIN_TMR1] <= FUNC_PERIPH;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        func_q[i] <= func_d[i];
      end
    end
  end

  // Network receive pin: only port function drives
  // independent port direction
  assign drv_en[PIN_NET_RX] = (func_q[PIN_NET_RX] == FUNC_PORT) & port_dir_i[PIN_NET_RX];
  assign drv_val[PIN_NET_RX] = port_data_i[PIN_NET_RX];
  assign drv_od[PIN_NET_RX] = port_open_drain_i[PIN_NET_RX];

  assign drv_en[PIN_NET_TX] = (func_q[PIN_NET_TX] == FUNC_PERIPH) |
                              ((func_q[PIN_NET_TX] == FUNC_PORT) & port_dir_i[PIN_NET_TX]);
  assign drv_val[PIN_NET_TX] = (func_q[PIN_NET_TX] == FUNC_PERIPH) ? net_tx_i
                                                                    : port_data_i[PIN_NET_TX];
  assign drv_od[PIN_NET_TX] = (func_q[PIN_NET_TX] == FUNC_PERIPH) ? 1'b1
                                                                   : port_open_drain_i[PIN_NET_TX];

  assign drv_en[PIN_TMR0] = ((func_q[PIN_TMR0] == FUNC_PERIPH) & tmr_oe_i[0]) |
                            (func_q[PIN_TMR0] == FUNC_ALT) |
                            ((func_q[PIN_TMR0] == FUNC_PORT) & port_dir_i[PIN_TMR0]);
  assign drv_val[PIN_TMR0] = (func_q[PIN_TMR0] == FUNC_PERIPH) ? tmr_out_i[0] :
                             (func_q[PIN_TMR0] == FUNC_ALT) ? serial_tx_alt_i
                                                            : port_data_i[PIN_TMR0];
  assign drv_od[PIN_TMR0] = (func_q[PIN_TMR0] == FUNC_PORT) & port_open_drain_i[PIN_TMR0];

  // Timer 1 pin: alternate function is serial receive, never drives
  assign drv_en[PIN_TMR1] = ((func_q[PIN_TMR1] == FUNC_PERIPH) & tmr_oe_i[1]) |
                            ((func_q[PIN_TMR1] == FUNC_PORT) & port_dir_i[PIN_TMR1]);
  assign drv_val[PIN_TMR1] = (func_q[PIN_TMR1] == FUNC_PERIPH) ? tmr_out_i[1]
                                                                : port_data_i[PIN_TMR1];
  assign drv_od[PIN_TMR1] = (func_q[PIN_TMR1] == FUNC_PORT) & port_open_drain_i[PIN_TMR1];

  // Pull-up bits: network transmit in network mode keeps register bit
  assign pu_bit = pullup_enable_reg_i;

  // Pad slices
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pad
    pin_pad_ctrl u_pad (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .drive_en_i(drv_en[g]),
      .drive_val_i(drv_val[g]),
      .open_drain_i(drv_od[g]),
      .pullup_bit_i(pu_bit[g]),
      .pad_out_o(pad_out_o[g]),
      .pad_oe_o(pad_oe_o[g]),
      .pad_pullup_o(pad_pullup_o[g])
    );
  end

  // Received data routing, idle level high for network and serial receive, low for timer inputs when not selected
  wire logic net_rx_d;
  wire logic [1:0] tmr_in_d;
  wire logic serial_rx_d;
  assign net_rx_d = (func_q[PIN_NET_RX] == FUNC_PERIPH) ? pad_in_i[PIN_NET_RX] : 1'b1;
  assign tmr_in_d[0] = (func_q[PIN_TMR0] == FUNC_PERIPH) ? pad_in_i[PIN_TMR0] : 1'b0;
  assign tmr_in_d[1] = (func_q[PIN_TMR1] == FUNC_PERIPH) ? pad_in_i[PIN_TMR1] : 1'b0;
  assign serial_rx_d = (func_q[PIN_TMR1] == FUNC_ALT) ? pad_in_i[PIN_TMR1] : 1'b1;

  // Registered receive outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      net_rx_o <= 1'b1;
      tmr_in_o <= 2'h0;
      serial_rx_alt_o <= 1'b1;
      port_in_o <= 4'h0;
      func_sel_o <= 8'h00;
    end else begin
      net_rx_o <= net_rx_d;
      tmr_in_o <= tmr_in_d;
      serial_rx_alt_o <= serial_rx_d;
      port_in_o <= pad_in_i;
      func_sel_o <= {func_q[3], func_q[2], func_q[1], func_q[0]};
    end
  end

  a_timer_default: assert property (@(posedge ref_clk_i)
    srst_i |=> func_q[PIN_TMR0] == FUNC_PERIPH && func_q[PIN_TMR1] == FUNC_PERIPH)
    else $error("timer pin default wrong");
  a_net_default: assert property (@(posedge ref_clk_i)
    srst_i |=> func_q[PIN_NET_TX] == NET_DEFAULT && func_q[PIN_NET_RX] == NET_DEFAULT)
    else $error("network pin default wrong");
  a_net_tx_od: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    func_q[PIN_NET_TX] == FUNC_PERIPH && net_tx_i |=> !pad_oe_o[PIN_NET_TX])
    else $error("network transmit drove high");
  a_port_dir: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    func_q[PIN_NET_RX] == FUNC_PORT && !port_dir_i[PIN_NET_RX] && !cfg_write_i
    |=> !pad_oe_o[PIN_NET_RX])
    else $error("input port pin driven");
  a_serial_rx: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    func_q[PIN_TMR1] == FUNC_ALT |=> serial_rx_alt_o == $past(pad_in_i[PIN_TMR1]))
    else $error("serial receive not routed");
  a_timer_reset: assert property (@(posedge ref_clk_i)
    srst_i |=> pad_pullup_o[PIN_TMR0] && pad_pullup_o[PIN_TMR1] && pad_oe_o == 4'h0)
    else $error("timer pin not input in reset");

  c_serial_tx: cover property (@(posedge ref_clk_i) func_q[PIN_TMR0] == FUNC_ALT && pad_oe_o[2]);
  c_port_mode: cover property (@(posedge ref_clk_i) func_q[PIN_NET_TX] == FUNC_PORT);
  c_net_low: cover property (@(posedge ref_clk_i)
    func_q[PIN_NET_TX] == FUNC_PERIPH && pad_oe_o[1]);

endmodule : pin_function_pullup_control
`default_nettype wire

// ---- pin_mux_pkg.sv ----
// Package of constants and types for the shared-pin function and pull-up control block
//
// Behaviour
// - Open-drain driving low turns pull-up off
// - Open-drain high keeps pull-up unless register cleared
// - Push-pull output always turns pull-up off
// - Network transmit pin open-drain in network mode, pull-up on at reset
// - Full variant defaults network pins; reduced none
// - Timer pins default to timer channel function
// - Each port pin has independent direction
// - Timer 0 offers serial transmit, timer 1 receive
package pin_mux_pkg;

  // Number of pins handled: 0 net rx, 1 net tx, 2 timer 0, 3 timer 1
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned PIN_NET_RX = 0;
  localparam int unsigned PIN_NET_TX = 1;
  localparam int unsigned PIN_TMR0 = 2;
  localparam int unsigned PIN_TMR1 = 3;

  // Reset value of the pull-up enable bits (all enabled)
  localparam logic [3:0] PULLUP_RESET = 4'hF;
  // Reset value of the port direction bits (all inputs)
  localparam logic [3:0] PORT_DIR_RESET = 4'h0;

  // Function selection of each pin
  typedef enum logic [1:0] {
    FUNC_NONE,
    FUNC_PERIPH,
    FUNC_ALT,
    FUNC_PORT
  } pin_func_t;

  // Output driver style
  typedef enum logic {
    DRIVE_PUSH_PULL,
    DRIVE_OPEN_DRAIN
  } drive_mode_t;

endpackage : pin_mux_pkg

// ---- pin_pad_ctrl.sv ----
// One pad slice: output enable, output level and pull-up gating
`timescale 1ns/1ps
`default_nettype none
module pin_pad_ctrl
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Requested drive
  input wire logic drive_en_i,
  input wire logic drive_val_i,
  input wire logic open_drain_i,
  input wire logic pullup_bit_i,
  // Pad controls
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic pad_pullup_o
);

  // Pull-up decision, combinational
  wire logic pullup_d;
  // Open-drain pad only drives when low
  wire logic oe_d;

  assign pullup_d = !drive_en_i ? pullup_bit_i :
                    open_drain_i ? (drive_val_i & pullup_bit_i) : 1'b0;
  assign oe_d = drive_en_i & (open_drain_i ? !drive_val_i : 1'b1);

  // Registered pad controls
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pad_out_o <= 1'b0;
      pad_oe_o <= 1'b0;
      pad_pullup_o <= 1'b1;
    end else begin
      pad_out_o <= open_drain_i ? 1'b0 : drive_val_i;
      pad_oe_o <= oe_d;
      pad_pullup_o <= pullup_d;
    end
  end

  a_od_low_pullup: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    drive_en_i && open_drain_i && !drive_val_i |=> !pad_pullup_o && pad_oe_o)
    else $error("pull-up on while open-drain low");
  a_od_high_pullup: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    drive_en_i && open_drain_i && drive_val_i
    |=> pad_pullup_o == $past(pullup_bit_i) && !pad_oe_o)
    else $error("open-drain high pull-up wrong");
  a_pp_pullup_off: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    drive_en_i && !open_drain_i
    |=> !pad_pullup_o && pad_oe_o && pad_out_o == $past(drive_val_i))
    else $error("push-pull pull-up not off");
  a_reset_input: assert property (@(posedge ref_clk_i)
    srst_i |=> !pad_oe_o && pad_pullup_o)
    else $error("pad drives after reset");

  c_od_low: cover property (@(posedge ref_clk_i) pad_oe_o && !pad_pullup_o);

endmodule : pin_pad_ctrl
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the shared-pin function and pull-up block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pin_mux_pkg::*;
  // Stimulus
  logic ref_clk_i, srst_i, cfg_write_i, net_tx, stx;
  logic [1:0] c_rx, c_tx, c_t0, c_t1, t_out, t_oe;
  logic [3:0] pue, dir, od, pdat, pin;
  // Design outputs
  logic [3:0] p_out, p_oe, p_pu, p_in, oe_r;
  logic nrx, srx;
  logic [1:0] tin;
  logic [7:0] fs, fs_r;
  // Model state, expectations and counters
  logic [1:0] fm [4];
  logic [3:0] e_oe, e_out;
  logic en, val, odm;
  int bad_count, total_checks;

  // Full variant under test
  pin_function_pullup_control #(.FULL_VARIANT(1'b1)) dut_u (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_write_i(cfg_write_i),
    .cfg_func_rx_i(c_rx), .cfg_func_tx_i(c_tx), .cfg_func_t0_i(c_t0),
    .cfg_func_t1_i(c_t1), .pullup_enable_reg_i(pue), .port_dir_i(dir),
    .port_open_drain_i(od), .port_data_i(pdat), .net_tx_i(net_tx),
    .tmr_out_i(t_out), .tmr_oe_i(t_oe), .serial_tx_alt_i(stx), .pad_in_i(pin),
    .pad_out_o(p_out), .pad_oe_o(p_oe), .pad_pullup_o(p_pu), .net_rx_o(nrx),
    .tmr_in_o(tin), .serial_rx_alt_o(srx), .port_in_o(p_in), .func_sel_o(fs));
  // Reduced variant, watched only for its reset defaults
  pin_function_pullup_control #(.FULL_VARIANT(1'b0)) dut_r (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_write_i(cfg_write_i),
    .cfg_func_rx_i(c_rx), .cfg_func_tx_i(c_tx), .cfg_func_t0_i(c_t0),
    .cfg_func_t1_i(c_t1), .pullup_enable_reg_i(pue), .port_dir_i(dir),
    .port_open_drain_i(od), .port_data_i(pdat), .net_tx_i(net_tx),
    .tmr_out_i(t_out), .tmr_oe_i(t_oe), .serial_tx_alt_i(stx), .pad_in_i(pin),
    .pad_out_o(), .pad_oe_o(oe_r), .pad_pullup_o(), .net_rx_o(),
    .tmr_in_o(), .serial_rx_alt_o(), .port_in_o(), .func_sel_o(fs_r));

  // Free-running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // One compare, counted
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Fresh random drive on every input except reset and write
  task automatic shake;
    {c_rx, c_tx, c_t0, c_t1} = 8'($urandom);
    {pue, dir, od, pdat} = 16'($urandom);
    {net_tx, stx, t_out, t_oe, pin} = 10'($urandom);
  endtask : shake

  // Steady-state model of the pads from current function and inputs
  task automatic compare_all;
    for (int i = 0; i < 4; i++) begin
      en = 1'b0;
      val = 1'b0;
      odm = 1'b0;
      if (fm[i] == 2'd1 && i == 1) begin
        en = 1'b1;
        val = net_tx;
        odm = 1'b1;
      end else if (fm[i] == 2'd1 && i >= 2) begin
        en = t_oe[i-2];
        val = t_out[i-2];
      end else if (fm[i] == 2'd2 && i == 2) begin
        en = 1'b1;
        val = stx;
      end else if (fm[i] == 2'd3) begin
        en = dir[i];
        val = pdat[i];
        odm = od[i];
      end
      e_oe[i] = en && !(odm && val);
      e_out[i] = e_oe[i] && !odm && val;
    end
    check(8'(p_oe), 8'(e_oe));
    check(8'(p_out & p_oe), 8'(e_out));
    check(8'(p_pu), 8'(~e_oe & pue));
    check(8'(nrx), (fm[0] == 2'd1) ? 8'(pin[0]) : 8'h01);
    check(8'(tin), {6'h00, fm[3] == 2'd1 && pin[3], fm[2] == 2'd1 && pin[2]});
    check(8'(srx), (fm[3] == 2'd2) ? 8'(pin[3]) : 8'h01);
    check(8'(p_in), 8'(pin));
    check(fs, {fm[3], fm[2], fm[1], fm[0]});
  endtask : compare_all

  // Reset with random inputs, then check defaults of both variants
  task automatic do_reset(input int cycles);
    srst_i = 1'b1;
    shake();
    repeat (cycles) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({p_oe, p_pu}, 8'h0F);
    check({7'h00, srx}, 8'h01);
    srst_i = 1'b0;
    fm = '{2'd1, 2'd1, 2'd1, 2'd1};
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(fs_r, 8'h50);
    check(8'(oe_r[1:0]), 8'h00);
    compare_all();
  endtask : do_reset

  // Print counts and verdict, then stop
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence: random configurations with resets in between
  initial begin
    bad_count = 0;
    total_checks = 0;
    cfg_write_i = 1'b0;
    void'($urandom(56048));
    do_reset(16);
    for (int n = 1; n <= 240; n++) begin
      @(negedge ref_clk_i);
      if (n % 60 == 0) begin
        do_reset(2);
      end else begin
        shake();
        cfg_write_i = 1'($urandom);
        // selects load only on a write
        if (cfg_write_i) begin
          fm = '{c_rx, c_tx, c_t0, c_t1};
        end
        @(negedge ref_clk_i);
        cfg_write_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        compare_all();
      end
    end
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
